// >>> src/ebc_pkg.sv
// constants and types for the external bus cycle controller
// How it works
// - five phases run strictly in sequence
// - setup 1-2 units plus 0-3 on window change
// - command, access, hold lengths from length inputs, not chip select
// - third phase sets data or floats bus
// - address and data held during hold phase
// - mux drives address then data; demux separate
// - read data captured when strobe rises
// - ready input may lengthen access phase
// - ready polarity selectable
// - sync ready taken after two flops, far side synchronous
// - async ready adds synchroniser stage
// - inactive ready inserts wait, active ends access phase
// - reference clock output from system clock
package ebc_pkg;
    localparam int          UNIT_DIV_DEFAULT = 2;
    localparam logic [1:0]  SETUP_EXT_MAX    = 2'h3;
    localparam logic [4:0]  ACCESS_RESET     = 5'h0;
    localparam int          CSEL_WIDTH       = 2;
    localparam int          WINDOW_MSB       = 23;
    localparam int          WINDOW_LSB       = 16;
    localparam int          REFCLK_DIV       = 2;

    typedef enum logic [6:0]
    {
        ST_IDLE  = 7'h01,
        ST_SETUP = 7'h02,
        ST_CMDD  = 7'h04,
        ST_WSET  = 7'h08,
        ST_ACC   = 7'h10,
        ST_WAIT  = 7'h20,
        ST_HOLD  = 7'h40
    } phase_t;
endpackage : ebc_pkg

// >>> src/unit_tick.sv
// timing unit divider giving a one-cycle enable pulse
`timescale 1ns/1ns
module unit_tick
    import ebc_pkg::*;
#(
    parameter int DIV = UNIT_DIV_DEFAULT
)
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic restart,
    output logic      tick
);
    initial
    begin
        if (DIV < 1 || DIV > 256)
            $error("unit_tick: DIV must be 1 to 256");
    end

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // restart aligns units to the setup start
    // tick is decoded, not registered, so the first unit is not stretched
    always_comb
    begin
        tick  = 1'b0;
        cnt_d = cnt_q + 8'h01;
        if (restart)
            cnt_d = 8'h00;
        else if (cnt_q == 8'(DIV - 1))
        begin
            cnt_d = 8'h00;
            tick  = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_d;
    end
endmodule : unit_tick

// >>> src/external_bus_cycle_control.sv
// external bus cycle sequencer with ready handshake
`timescale 1ns/1ns
module external_bus_cycle_control
    import ebc_pkg::*;
#(
    parameter int UNIT_DIV = UNIT_DIV_DEFAULT
)
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        req,
    input  wire logic        req_write,
    input  wire logic        req_high_byte,
    input  wire logic [23:0] req_addr,
    input  wire logic [15:0] req_wdata,
    input  wire logic [1:0]  req_csel,
    input  wire logic        mux_mode,
    input  wire logic        setup_long,
    input  wire logic [1:0]  setup_ext,
    input  wire logic [1:0]  cmd_len,
    input  wire logic        wset_len,
    input  wire logic [4:0]  acc_len,
    input  wire logic [1:0]  hold_len,
    input  wire logic        ready_en,
    input  wire logic        ready_act_low,
    input  wire logic        ready_async,
    input  wire logic        refclk_en,
    input  wire logic        ready_pin,
    input  wire logic [15:0] shared_addr_data_lines_in,
    input  wire logic [15:0] separate_data_lines_in,
    output logic             busy,
    output logic             done,
    output logic [15:0]      rdata,
    output logic [23:0]      address_lines,
    output logic [15:0]      shared_addr_data_lines_out,
    output logic             shared_addr_data_lines_oe,
    output logic [15:0]      separate_data_lines_out,
    output logic             separate_data_lines_oe,
    output logic             rd_n,
    output logic             wr_n,
    output logic             high_byte_enable_n,
    output logic             ale,
    output logic             bus_reference_clock_out
);
    initial
    begin
        if (UNIT_DIV < 1 || UNIT_DIV > 255)
            $error("UNIT_DIV out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // ready synchronisers
    logic rdy_s1_q, rdy_s2_q, rdy_s3_q;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
            rdy_s3_q <= 1'b0;
        end
        else
        begin
            rdy_s1_q <= ready_pin;
            rdy_s2_q <= rdy_s1_q;
            rdy_s3_q <= rdy_s2_q;
        end
    end

    logic rdy_active;
    always_comb
    begin
        // sync path: pin already meets setup to the unit edge
        rdy_active = (ready_async ? rdy_s3_q : rdy_s2_q);
        rdy_active = rdy_active ^ ready_act_low;
    end

    ////////////////////////////////////////////////////////////////////////
    // timing unit and sequencer
    logic tick;
    logic unit_restart;
    unit_tick #(.DIV(UNIT_DIV)) u_tick
    (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .restart (unit_restart),
        .tick    (tick)
    );

    phase_t      ph_q, ph_d;
    logic [5:0]  left_q, left_d;
    logic [7:0]  win_q, win_d;
    logic        win_vld_q, win_vld_d;
    logic        wr_q, wr_d;
    logic        mux_q, mux_d;
    logic [1:0]  cs_q, cs_d;
    logic [23:0] addr_q, addr_d;
    logic [15:0] wdat_q, wdat_d;
    logic [15:0] rdat_q, rdat_d;
    logic [15:0] adout_d, dout_d;
    logic        adoe_d, doe_d, rd_d, wrn_d, bhe_d, ale_d, busy_d, done_d;
    logic        hb_q, hb_d;
    logic        rdy_q, rdy_d;

    assign unit_restart = (ph_q == ST_IDLE);

    always_comb
    begin
        ph_d      = ph_q;
        left_d    = left_q;
        win_d     = win_q;
        win_vld_d = win_vld_q;
        wr_d      = wr_q;
        mux_d     = mux_q;
        cs_d      = cs_q;
        addr_d    = addr_q;
        wdat_d    = wdat_q;
        rdat_d    = rdat_q;
        hb_d      = hb_q;
        rdy_d     = rdy_q;
        done_d    = 1'b0;
        case (ph_q)
            ST_IDLE:
            begin
                if (req)
                begin
                    ph_d   = ST_SETUP;
                    wr_d   = req_write;
                    mux_d  = mux_mode;
                    cs_d   = req_csel;
                    addr_d = req_addr;
                    wdat_d = req_wdata;
                    hb_d   = req_high_byte;
                    rdy_d  = ready_en;
                    // base 1-2 units, plus 0-3 on window change
                    left_d = 6'({1'b0, setup_long}) + 6'h1;
                    if (!win_vld_q || req_addr[WINDOW_MSB:WINDOW_LSB] != win_q)
                        left_d = left_d + 6'({1'b0, setup_ext});
                    win_d     = req_addr[WINDOW_MSB:WINDOW_LSB];
                    win_vld_d = 1'b1;
                end
            end
            ST_SETUP, ST_CMDD, ST_WSET, ST_HOLD:
            begin
                if (tick)
                    left_d = left_q - 6'h1;
                if (tick && left_q == 6'h1)
                begin
                    // strict phase order, zero-length phases skipped
                    // lengths from the cmd_len, wset_len and acc_len inputs
                    if (ph_q == ST_SETUP && cmd_len != 2'h0)
                    begin
                        ph_d   = ST_CMDD;
                        left_d = 6'(cmd_len);
                    end
                    else if (ph_q != ST_HOLD && ph_q != ST_WSET && wset_len)
                    begin
                        ph_d   = ST_WSET;
                        left_d = 6'(wset_len);
                    end
                    else if (ph_q != ST_HOLD)
                    begin
                        ph_d   = ST_ACC;
                        left_d = 6'(acc_len) + 6'h1;
                    end
                    else
                    begin
                        ph_d   = ST_IDLE;
                        done_d = 1'b1;
                    end
                end
            end
            ST_ACC, ST_WAIT:
            begin
                if (tick && ph_q == ST_ACC)
                    left_d = left_q - 6'h1;
                // ready only looked at after minimum access
                if (tick && (ph_q == ST_WAIT || left_q == 6'h1))
                begin
                    // inactive ready inserts a wait unit
                    // async ready always costs one wait unit
                    if (rdy_q && (!rdy_active || ready_async && ph_q == ST_ACC))
                        ph_d = ST_WAIT;
                    else
                    begin
                        // capture on the edge that raises the strobe
                        if (!wr_q)
                            rdat_d = mux_q ? shared_addr_data_lines_in
                                           : separate_data_lines_in;
                        ph_d   = (hold_len != 2'h0) ? ST_HOLD : ST_IDLE;
                        done_d = (hold_len == 2'h0);
                        left_d = 6'(hold_len);
                    end
                end
            end
            default:
            begin
                ph_d = ST_IDLE;
            end
        endcase
    end

    always_comb
    begin
        busy_d  = (ph_d != ST_IDLE);
        ale_d   = 1'b0;
        rd_d    = 1'b1;
        wrn_d   = 1'b1;
        bhe_d   = !(hb_d && busy_d);
        adout_d = addr_d[15:0];
        adoe_d  = 1'b0;
        dout_d  = wdat_d;
        doe_d   = 1'b0;
        // latch pulse in mux setup phase
        if (ph_d == ST_SETUP && mux_d)
            ale_d = 1'b1;
        if (busy_d && mux_d)
        begin
            // address first, then write data on shared lines
            // reads float shared lines from the third phase on
            adoe_d = (ph_d == ST_SETUP || ph_d == ST_CMDD) || wr_d;
            if (wr_d && !(ph_d == ST_SETUP || ph_d == ST_CMDD))
                adout_d = wdat_d;
        end
        if (busy_d && !mux_d && wr_d && ph_d != ST_SETUP && ph_d != ST_CMDD)
            doe_d = 1'b1;
        // address and data stand through hold; strobes go high
        if (ph_d == ST_ACC || ph_d == ST_WAIT)
        begin
            rd_d  = wr_d;
            wrn_d = !wr_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ph_q      <= ST_IDLE;
            left_q    <= 6'h00;
            win_q     <= 8'h00;
            win_vld_q <= 1'b0;
            wr_q      <= 1'b0;
            mux_q     <= 1'b0;
            cs_q      <= 2'h0;
            addr_q    <= 24'h000000;
            wdat_q    <= 16'h0000;
            rdat_q    <= 16'h0000;
            hb_q      <= 1'b0;
            rdy_q     <= 1'b0;
            busy      <= 1'b0;
            done      <= 1'b0;
            ale       <= 1'b0;
            rd_n      <= 1'b1;
            wr_n      <= 1'b1;
            high_byte_enable_n         <= 1'b1;
            shared_addr_data_lines_out <= 16'h0000;
            shared_addr_data_lines_oe  <= 1'b0;
            separate_data_lines_out    <= 16'h0000;
            separate_data_lines_oe     <= 1'b0;
            address_lines <= 24'h000000;
            rdata         <= 16'h0000;
        end
        else
        begin
            ph_q      <= ph_d;
            left_q    <= left_d;
            win_q     <= win_d;
            win_vld_q <= win_vld_d;
            wr_q      <= wr_d;
            mux_q     <= mux_d;
            cs_q      <= cs_d;
            addr_q    <= addr_d;
            wdat_q    <= wdat_d;
            rdat_q    <= rdat_d;
            hb_q      <= hb_d;
            rdy_q     <= rdy_d;
            busy      <= busy_d;
            done      <= done_d;
            ale       <= ale_d;
            rd_n      <= rd_d;
            wr_n      <= wrn_d;
            high_byte_enable_n         <= bhe_d;
            shared_addr_data_lines_out <= adout_d;
            shared_addr_data_lines_oe  <= adoe_d;
            separate_data_lines_out    <= dout_d;
            separate_data_lines_oe     <= doe_d;
            address_lines <= addr_d;
            rdata         <= rdat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference clock: half rate of mclk, enable gated
    logic refclk_d;
    always_comb
    begin
        // derived straight from the system clock
        refclk_d = refclk_en ? !bus_reference_clock_out : 1'b0;
    end
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            bus_reference_clock_out <= 1'b0;
        else
            bus_reference_clock_out <= refclk_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_ale_only_setup: assert property (@(posedge mclk) disable iff (!rst_n)
        ale |-> (ph_q == ST_SETUP && mux_q))
        else $error("ale outside mux setup");
    a_no_both_strobes: assert property (@(posedge mclk) disable iff (!rst_n)
        !(!rd_n && !wr_n))
        else $error("both strobes low");
    a_strobe_in_access: assert property (@(posedge mclk) disable iff (!rst_n)
        (!rd_n || !wr_n) |-> (ph_q == ST_ACC || ph_q == ST_WAIT))
        else $error("strobe outside access");
    a_wait_only_ready: assert property (@(posedge mclk) disable iff (!rst_n)
        (ph_q == ST_WAIT) |-> rdy_q)
        else $error("wait without ready control");
    a_rdata_on_rise: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(rdata) |-> $rose(rd_n))
        else $error("read data changed off strobe edge");
    a_hold_addr_stable: assert property (@(posedge mclk) disable iff (!rst_n)
        (ph_q == ST_HOLD && $past(ph_q) == ST_HOLD) |-> $stable(address_lines))
        else $error("address moved in hold");
    a_read_float: assert property (@(posedge mclk) disable iff (!rst_n)
        (!rd_n && mux_q) |-> !shared_addr_data_lines_oe)
        else $error("shared lines driven during read");
    a_demux_data: assert property (@(posedge mclk) disable iff (!rst_n)
        separate_data_lines_oe |-> (wr_q && !mux_q))
        else $error("separate data driven wrongly");
endmodule : external_bus_cycle_control

// >>> bench/ext_mem_model.sv
// external memory with ready handshake facing the bus controller
`timescale 1ns/1ns
module ext_mem_model
(
    input  wire logic        mclk,
    input  wire logic        mux_mode,
    input  wire logic        act_low,
    input  wire logic [7:0]  ready_delay,
    input  wire logic [23:0] address_lines,
    input  wire logic [15:0] ad_out,
    input  wire logic        ad_oe,
    input  wire logic [15:0] d_out,
    input  wire logic        d_oe,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        ale,
    output logic [15:0]      ad_in,
    output logic [15:0]      d_in,
    output logic             ready_pin
);
    logic [15:0] mem [0:255];
    logic [15:0] wbuf_q;
    logic [15:0] last_q = 16'hA5A5;
    logic [15:0] rd_val;
    logic [7:0]  lat_q;
    logic [7:0]  idx;
    logic [7:0]  cnt_q = 8'h00;
    logic        wr_p_q = 1'b1;
    logic        rdy_q = 1'b0;
    assign idx    = mux_mode ? lat_q : address_lines[7:0];
    assign rd_val = mem[idx];
    // released lines show the inverse of the last value
    assign ad_in = ad_oe ? ad_out : ((!rd_n && mux_mode) ? rd_val : ~last_q);
    assign d_in  = d_oe ? d_out : ((!rd_n && !mux_mode) ? rd_val : ~last_q);
    // ready withdrawn as the strobe rises
    assign ready_pin = act_low ^ (rdy_q && !(rd_n && wr_n));
    ////////////////////////////////////////////////////////////////
    always @(posedge mclk)
    begin
        wr_p_q <= wr_n;
        if (ale) lat_q <= ad_out[7:0];
        if (!wr_n) wbuf_q <= mux_mode ? ad_out : d_out;
        if (wr_n && !wr_p_q) mem[idx] <= wbuf_q;
        if (!rd_n) last_q <= rd_val;
        // ready moves after an edge, held until strobe ends
        cnt_q <= (rd_n && wr_n) ? 8'h00 : cnt_q + 8'h01;
        rdy_q <= !(rd_n && wr_n) && (cnt_q >= ready_delay);
    end
endmodule : ext_mem_model

// >>> bench/tb_external_bus_cycle_control.sv
// self-checking bench for the external bus cycle controller
`timescale 1ns/1ns
module tb_external_bus_cycle_control;
    import ebc_pkg::*;
    localparam int UD = 2;
    logic        mclk = 0, rst_n = 0, req = 0, req_write = 0, req_high_byte = 0;
    logic [23:0] req_addr = 24'h0, address_lines, a_q;
    logic [15:0] req_wdata = 16'h0, rdata, ad_out, ad_in, d_out, d_in;
    logic [1:0]  req_csel = 2'h1, setup_ext = 2'h0, cmd_len = 2'h0, hold_len = 2'h0;
    logic [4:0]  acc_len = 5'h0;
    logic [7:0]  ready_delay = 8'h00;
    logic        mux_mode = 0, setup_long = 0, wset_len = 0, ready_en = 0;
    logic        ready_act_low = 0, ready_async = 0, refclk_en = 0, ready_pin;
    logic        busy, done, ad_oe, d_oe, rd_n, wr_n, hbe_n, ale, refclk, hbe_q;
    int          lo_n, ale_n, failures = 0, num_checks = 0;
    logic [23:0] ta [4] = '{24'h010005, 24'h010006, 24'h010005, 24'h020006};
    logic [15:0] td [4] = '{16'h1234, 16'hBEEF, 16'h1234, 16'hBEEF};
    int          tu [4] = '{5, 2, 2, 5};

    always #2 mclk = ~mclk;

    external_bus_cycle_control #(.UNIT_DIV(UD)) external_bus_cycle_control_i
    (
        .mclk(mclk), .rst_n(rst_n), .req(req), .req_write(req_write),
        .req_high_byte(req_high_byte), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_csel(req_csel), .mux_mode(mux_mode), .setup_long(setup_long),
        .setup_ext(setup_ext), .cmd_len(cmd_len), .wset_len(wset_len),
        .acc_len(acc_len), .hold_len(hold_len), .ready_en(ready_en),
        .ready_act_low(ready_act_low), .ready_async(ready_async),
        .refclk_en(refclk_en), .ready_pin(ready_pin),
        .shared_addr_data_lines_in(ad_in), .separate_data_lines_in(d_in),
        .busy(busy), .done(done), .rdata(rdata), .address_lines(address_lines),
        .shared_addr_data_lines_out(ad_out), .shared_addr_data_lines_oe(ad_oe),
        .separate_data_lines_out(d_out), .separate_data_lines_oe(d_oe),
        .rd_n(rd_n), .wr_n(wr_n), .high_byte_enable_n(hbe_n), .ale(ale),
        .bus_reference_clock_out(refclk)
    );

    ext_mem_model ext_mem_model_i
    (
        .mclk(mclk), .mux_mode(mux_mode), .act_low(ready_act_low),
        .ready_delay(ready_delay), .address_lines(address_lines), .ad_out(ad_out),
        .ad_oe(ad_oe), .d_out(d_out), .d_oe(d_oe), .rd_n(rd_n), .wr_n(wr_n),
        .ale(ale), .ad_in(ad_in), .d_in(d_in), .ready_pin(ready_pin)
    );
    ////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp

    task automatic stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // one access: hold req until taken, then wait for done
    task automatic access(input logic w, input logic [23:0] a, input logic [15:0] d);
        int n;
        @(posedge mclk);
        req <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        n = 0;
        while (busy !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
        req <= 1'b0;
        while (done !== 1'b1 && n < 600)
        begin
            @(negedge mclk);
            n++;
        end
        cmp(n < 600, 1);
    endtask : access
    ////////////////////////////////////////////////////////////////
    always @(posedge mclk)
    begin
        if (req && !busy)
        begin
            lo_n <= 0;
            ale_n <= 0;
        end
        else
        begin
            if (!rd_n || !wr_n) lo_n <= lo_n + 1;
            if (ale) ale_n <= ale_n + 1;
        end
        if (!rd_n || !wr_n) a_q <= address_lines;
        if (!rd_n || !wr_n) hbe_q <= hbe_n;
        // address stands through the hold phase
        if (busy && lo_n > 0 && rd_n && wr_n) cmp(address_lines, a_q);
    end

    initial
    begin
        #40000;
        failures++;
        stop_test();
    end

    initial
    begin
        int lo, hi, rn;
        logic pv;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        cmp({rd_n, wr_n, ale, busy, ad_oe, d_oe}, 32'h30);
        @(posedge mclk);
        mux_mode <= 1'b1;
        setup_long <= 1'b1;
        setup_ext <= 2'h3;
        cmd_len <= 2'h3;
        wset_len <= 1'b1;
        acc_len <= 5'h1F;
        hold_len <= 2'h3;
        for (int i = 0; i < 4; i++)
        begin
            access(i < 2, ta[i], td[i]);
            cmp(ale_n, tu[i] * UD);
            cmp(lo_n, 32 * UD);
            if (i > 1) cmp(rdata, td[i]);
        end
        $display("multiplexed test done");
        @(posedge mclk);
        mux_mode <= 1'b0;
        setup_long <= 1'b0;
        setup_ext <= 2'h0;
        cmd_len <= 2'h0;
        wset_len <= 1'b0;
        acc_len <= 5'h00;
        hold_len <= 2'h0;
        req_high_byte <= 1'b1;
        access(1'b1, 24'h000011, 16'hCAFE);
        cmp(lo_n, UD);
        cmp(hbe_q, 1'b0);
        access(1'b0, 24'h000011, 16'h0000);
        cmp(ale_n, 0);
        cmp(rdata, 16'hCAFE);
        $display("demultiplexed test done");
        @(posedge mclk);
        ready_en <= 1'b1;
        acc_len <= 5'h03;
        for (int k = 0; k < 8; k++)
        begin
            @(posedge mclk);
            ready_act_low <= k[0];
            ready_async <= k[1];
            ready_delay <= k[2] ? 8'h1E : 8'h00;
            access(1'b0, 24'h000011, 16'h0000);
            cmp(rdata, 16'hCAFE);
            lo = k[2] ? 32 : (k[1] ? 5 * UD : 4 * UD);
            hi = k[2] ? 46 : (k[1] ? 8 * UD : 4 * UD);
            cmp(lo_n >= lo && lo_n <= hi && lo_n % UD == 0, 1);
        end
        $display("ready test done");
        for (int e = 0; e < 2; e++)
        begin
            @(posedge mclk);
            refclk_en <= e[0];
            repeat (4) @(posedge mclk);
            rn = 0;
            pv = refclk;
            repeat (20)
            begin
                @(negedge mclk);
                if (refclk && !pv) rn++;
                pv = refclk;
            end
            cmp(rn, e * 10);
        end
        $display("reference clock test done");
        stop_test();
    end
endmodule : tb_external_bus_cycle_control
